// file: verilog/ea_sync_action.sv
`include "ea_consts.svh"

module ea_sync_action
  import ea_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic            cmdStb,
  input  wire logic [7:0]      cmdCode,
  input  wire logic [15:0]     cmdParam,
  input  wire logic [3:0]      mrWriteStb,
  input  wire logic [31:0]     mrWriteData,
  input  wire logic [31:0]     logicalPos,
  input  wire logic [31:0]     realPos,
  input  wire logic [31:0]     presentPulseRate,
  input  wire logic [31:0]     presentAccel,
  input  wire logic [31:0]     currentTimer,
  input  wire logic            driving,
  input  wire logic [3:0]      mrCompareTrue,
  input  wire logic            timerUp,
  input  wire logic            driveStart,
  input  wire logic            constSpeedStart,
  input  wire logic            constSpeedEnd,
  input  wire logic            driveEnd,
  input  wire logic            splitStart,
  input  wire logic            splitEnd,
  input  wire logic            splitPulse,
  input  wire logic [7:0]      generalPinIn,
  output logic      [3:0]      generalPinOut,
  output logic      [3:0]      generalPinOeN,
  output logic      [3:0]      setEnabled,
  output logic      [15:0]     readDataLow,
  output logic      [15:0]     readDataHigh,
  output logic                 readValid,
  output logic      [6:0]      loadStb,
  output logic      [6:0][31:0] loadValue,
  output logic      [14:0]     driveStb
);

  localparam int READ_MAX_CYC =
    (`EA_READ_MAX_NS * `EA_CLK_MHZ) / `EA_NS_PER_US;

  ea_state_s  s_r;
  ea_state_s  s_nxt;
  logic [7:0] pinLevel;
  logic [7:0] pinRise;
  logic [7:0] pinFall;
  logic [3:0] trig;
  logic [3:0] direct;
  logic [3:0] chained;
  logic [3:0] fire;
  logic [3:0] enableSet;
  logic [3:0] oneShotClr;
  logic [7:0] modeIdx;
  logic [4:0] act;
  logic [4:0] driveIdx;
  logic [1:0] tgt;
  ea_long_t   rd;

  ea_pin_sync u_pins (
    .clk      (clk),
    .rst      (rst),
    .pinIn    (generalPinIn),
    .pinLevel (pinLevel),
    .pinRise  (pinRise),
    .pinFall  (pinFall)
  );

  // Selects whether a set's trigger code matches this cycle's events.
  function automatic logic ea_trig_hit(
    input logic [3:0] code,
    input logic       mrCmp,
    input logic       rise,
    input logic       fall,
    input logic       hi,
    input logic [7:0] ev
  );
    logic hit;
    hit = 1'b0;
    case (code)
      `EA_TRG_MR_CMP:    hit = mrCmp;
      `EA_TRG_TIMER_UP:  hit = ev[0];
      `EA_TRG_DRV_START: hit = ev[1];
      `EA_TRG_CSP_START: hit = ev[2];
      `EA_TRG_CSP_END:   hit = ev[3];
      `EA_TRG_DRV_END:   hit = ev[4];
      `EA_TRG_SPL_START: hit = ev[5];
      `EA_TRG_SPL_END:   hit = ev[6];
      `EA_TRG_SPL_PULSE: hit = ev[7];
      `EA_TRG_PIN_RISE:  hit = rise;
      `EA_TRG_PIN_FALL:  hit = fall;
      `EA_TRG_LO_RISE:   hit = rise & ~hi;
      `EA_TRG_HI_RISE:   hit = rise & hi;
      `EA_TRG_LO_FALL:   hit = fall & ~hi;
      `EA_TRG_HI_FALL:   hit = fall & hi;
      default:           hit = 1'b0;
    endcase
    return hit;
  endfunction : ea_trig_hit

  ////////////////////////////////////////////////////////////////////////////

  // Trigger detection and chaining; chained sets are only reached from
  // directly triggered ones, so each set is evaluated once per cycle.
  always_comb
  begin
    chained = '0;
    for (int i = 0; i < 4; i++)
    begin
      trig[i] = ea_trig_hit(
        s_r.mode[i][`EA_TRIG_MSB:`EA_TRIG_LSB], mrCompareTrue[i],
        pinRise[i], pinFall[i], pinLevel[i + 4],
        {splitPulse, splitEnd, splitStart, driveEnd, constSpeedEnd,
         constSpeedStart, driveStart, timerUp});
      direct[i] = s_r.enabled[i] & trig[i];
    end
    for (int i = 0; i < 4; i++)
    begin
      for (int k = 1; k < 4; k++)
      begin
        if (direct[i] && s_r.mode[i][`EA_CHAIN_LSB + k - 1])
          chained[2'(i + k)] = 1'b1;
      end
    end
    fire = s_r.enabled & (direct | chained);
  end

  ////////////////////////////////////////////////////////////////////////////

  always_comb
  begin
    s_nxt           = s_r;
    s_nxt.loadStb   = '0;
    s_nxt.driveStb  = '0;
    s_nxt.syncPulse = '0;
    s_nxt.readValid = 1'b0;
    enableSet       = '0;
    oneShotClr      = '0;
    act             = '0;
    driveIdx        = '0;
    tgt             = '0;
    rd              = '0;
    modeIdx         = cmdCode - `EA_CMD_MODE0;

    if (cmdStb)
    begin
      if (cmdCode >= `EA_CMD_MODE0 && cmdCode <= `EA_CMD_MODE3)
        s_nxt.mode[modeIdx[1:0]] = cmdParam & `EA_MODE_KEEP_MASK;
      if (cmdCode == `EA_CMD_SET_ENABLE)
        enableSet = cmdParam[3:0];
      s_nxt.readValid = 1'b1;
      case (cmdCode)
        `EA_CMD_RD_LPOS: rd = logicalPos;
        `EA_CMD_RD_RPOS: rd = realPos;
        `EA_CMD_RD_RATE: rd = driving ? presentPulseRate : '0;
        `EA_CMD_RD_ACC:  rd = driving ? presentAccel : '0;
        `EA_CMD_RD_TMR:  rd = driving ? currentTimer : '0;
        default:
        begin
          if (cmdCode >= `EA_CMD_RD_GPR0 && cmdCode <= `EA_CMD_RD_GPR3)
            rd = s_r.mr[2'(cmdCode - `EA_CMD_RD_GPR0)];
          else
            s_nxt.readValid = 1'b0;
        end
      endcase
      if (s_nxt.readValid)
      begin
        s_nxt.readLow  = rd[15:0];
        s_nxt.readHigh = rd[31:16];
      end
    end

    for (int i = 0; i < 4; i++)
    begin
      if (mrWriteStb[i])
        s_nxt.mr[i] = mrWriteData;
    end

    // Later sets overwrite earlier ones where they hit the same target.
    for (int i = 0; i < 4; i++)
    begin
      if (fire[i])
      begin
        act = s_r.mode[i][`EA_ACT_MSB:`EA_ACT_LSB];
        tgt = 2'(i);
        if (!s_r.mode[i][`EA_REPEAT_BIT])
          oneShotClr[i] = 1'b1;
        case (act)
          `EA_ACT_LOAD_SPD:
          begin
            s_nxt.loadStb[`EA_TGT_SPD]   = 1'b1;
            s_nxt.loadValue[`EA_TGT_SPD] = s_r.mr[i];
          end
          `EA_ACT_LOAD_CNT:
          begin
            s_nxt.loadStb[`EA_TGT_CNT]   = 1'b1;
            s_nxt.loadValue[`EA_TGT_CNT] = s_r.mr[i];
          end
          `EA_ACT_LOAD_SET:
          begin
            s_nxt.loadStb[`EA_TGT_LPOS + tgt]   = 1'b1;
            s_nxt.loadValue[`EA_TGT_LPOS + tgt] = s_r.mr[i];
          end
          `EA_ACT_SAVE_LPOS: s_nxt.mr[i] = logicalPos;
          `EA_ACT_SAVE_RPOS: s_nxt.mr[i] = realPos;
          `EA_ACT_SAVE_TMR:  s_nxt.mr[i] = currentTimer;
          `EA_ACT_SAVE_RATE:
          begin
            if (i == 0)
              s_nxt.mr[i] = presentPulseRate;
            else if (i == 1)
              s_nxt.mr[i] = presentAccel;
          end
          `EA_ACT_SYNC_PULSE: s_nxt.syncPulse[i] = 1'b1;
          default:
          begin
            if (act >= `EA_ACT_DRIVE_LO && act <= `EA_ACT_DRIVE_HI)
            begin
              driveIdx = act - `EA_ACT_DRIVE_LO;
              s_nxt.driveStb[driveIdx[3:0]] = 1'b1;
            end
            if (act == `EA_ACT_REL_GPR)
            begin
              s_nxt.loadStb[`EA_TGT_CNT]   = 1'b1;
              s_nxt.loadValue[`EA_TGT_CNT] = s_r.mr[i];
            end
            if (act == `EA_ACT_ABS_GPR)
            begin
              s_nxt.loadStb[`EA_TGT_FP]   = 1'b1;
              s_nxt.loadValue[`EA_TGT_FP] = s_r.mr[i];
            end
          end
        endcase
      end
    end

    // An enable command in the same cycle as a one-shot firing wins.
    s_nxt.enabled = (s_r.enabled & ~oneShotClr) | enableSet;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_r      <= '0;
      s_r.mode <= {4{`EA_MODE_RESET}};
    end
    else
      s_r <= s_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////

  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      generalPinOeN[i] =
        s_r.mode[i][`EA_ACT_MSB:`EA_ACT_LSB] != `EA_ACT_SYNC_PULSE;
    end
  end

  assign generalPinOut = s_r.syncPulse;
  assign setEnabled    = s_r.enabled;
  assign readDataLow   = s_r.readLow;
  assign readDataHigh  = s_r.readHigh;
  assign readValid     = s_r.readValid;
  assign loadStb       = s_r.loadStb;
  assign loadValue     = s_r.loadValue;
  assign driveStb      = s_r.driveStb;

  ////////////////////////////////////////////////////////////////////////////

  property p_mode_write;
    @(posedge clk) disable iff (rst)
    cmdStb && cmdCode == `EA_CMD_MODE0 |=>
      s_r.mode[0] == ($past(cmdParam) & `EA_MODE_KEEP_MASK);
  endproperty
  a_mode_write: assert property (p_mode_write)
    else $error("mode word 0 not stored");

  property p_one_shot;
    @(posedge clk) disable iff (rst)
    fire[3] && !s_r.mode[3][`EA_REPEAT_BIT] && !enableSet[3] |=>
      !setEnabled[3];
  endproperty
  a_one_shot: assert property (p_one_shot)
    else $error("one-shot set still enabled");

  property p_repeat;
    @(posedge clk) disable iff (rst)
    fire[1] && s_r.mode[1][`EA_REPEAT_BIT] |=> setEnabled[1];
  endproperty
  a_repeat: assert property (p_repeat)
    else $error("repeat set was disabled");

  property p_stays_off;
    @(posedge clk) disable iff (rst)
    !setEnabled[0] && !(cmdStb && cmdCode == `EA_CMD_SET_ENABLE) |=>
      !setEnabled[0];
  endproperty
  a_stays_off: assert property (p_stays_off)
    else $error("set re-enabled without command");

  property p_read_lp;
    @(posedge clk) disable iff (rst)
    cmdStb && cmdCode == `EA_CMD_RD_LPOS |=>
      {readDataHigh, readDataLow} == $past(logicalPos) && readValid;
  endproperty
  a_read_lp: assert property (p_read_lp)
    else $error("logical position read wrong");

  property p_read_cv_stopped;
    @(posedge clk) disable iff (rst)
    cmdStb && cmdCode == `EA_CMD_RD_RATE && !driving |=>
      readDataLow == 16'h0000 && readDataHigh == 16'h0000;
  endproperty
  a_read_cv_stopped: assert property (p_read_cv_stopped)
    else $error("pulse rate not zero while stopped");

  property p_read_time;
    @(posedge clk) disable iff (rst)
    cmdStb && cmdCode == `EA_CMD_RD_RPOS |-> ##[1:READ_MAX_CYC] readValid;
  endproperty
  a_read_time: assert property (p_read_time)
    else $error("read answer too late");

  property p_chain;
    @(posedge clk) disable iff (rst)
    direct[3] && s_r.mode[3][`EA_CHAIN_LSB] && s_r.enabled[0] |-> fire[0];
  endproperty
  a_chain: assert property (p_chain)
    else $error("chained set not fired");

  property p_sync_pulse;
    @(posedge clk) disable iff (rst)
    fire[3] && s_r.mode[3][`EA_ACT_MSB:`EA_ACT_LSB] == `EA_ACT_SYNC_PULSE
      |=> generalPinOut[3] && !generalPinOeN[3] ##1 !generalPinOut[3];
  endproperty
  a_sync_pulse: assert property (p_sync_pulse)
    else $error("sync pulse not one cycle");

  property p_dec_stop;
    @(posedge clk) disable iff (rst)
    fire[0] && s_r.mode[0][`EA_ACT_MSB:`EA_ACT_LSB] == `EA_ACT_DEC_STOP
      |=> driveStb[7];
  endproperty
  a_dec_stop: assert property (p_dec_stop)
    else $error("decelerating stop not issued");

endmodule : ea_sync_action

// file: verilog/ea_consts.svh
`ifndef EA_CONSTS_SVH
`define EA_CONSTS_SVH

// Command codes written through the command port.
`define EA_CMD_MODE0      8'h26
`define EA_CMD_MODE3      8'h29
`define EA_CMD_RD_LPOS    8'h30
`define EA_CMD_RD_RPOS    8'h31
`define EA_CMD_RD_RATE    8'h32
`define EA_CMD_RD_ACC     8'h33
`define EA_CMD_RD_GPR0    8'h34
`define EA_CMD_RD_GPR3    8'h37
`define EA_CMD_RD_TMR     8'h38
`define EA_CMD_SET_ENABLE 8'h8A

// Mode word layout.
`define EA_MODE_RESET     16'h0000
`define EA_MODE_KEEP_MASK 16'h8FFF
`define EA_TRIG_MSB       3
`define EA_TRIG_LSB       0
`define EA_ACT_MSB        8
`define EA_ACT_LSB        4
`define EA_CHAIN_LSB      9
`define EA_REPEAT_BIT     15

// Trigger codes.
`define EA_TRG_MR_CMP     4'h1
`define EA_TRG_TIMER_UP   4'h2
`define EA_TRG_DRV_START  4'h3
`define EA_TRG_CSP_START  4'h4
`define EA_TRG_CSP_END    4'h5
`define EA_TRG_DRV_END    4'h6
`define EA_TRG_SPL_START  4'h7
`define EA_TRG_SPL_END    4'h8
`define EA_TRG_SPL_PULSE  4'h9
`define EA_TRG_PIN_RISE   4'hA
`define EA_TRG_PIN_FALL   4'hB
`define EA_TRG_LO_RISE    4'hC
`define EA_TRG_HI_RISE    4'hD
`define EA_TRG_LO_FALL    4'hE
`define EA_TRG_HI_FALL    4'hF

// Action codes.
`define EA_ACT_LOAD_SPD   5'h01
`define EA_ACT_LOAD_CNT   5'h02
`define EA_ACT_LOAD_SET   5'h04
`define EA_ACT_SAVE_LPOS  5'h05
`define EA_ACT_SAVE_RPOS  5'h06
`define EA_ACT_SAVE_TMR   5'h07
`define EA_ACT_SAVE_RATE  5'h08
`define EA_ACT_SYNC_PULSE 5'h09
`define EA_ACT_DRIVE_LO   5'h0A
`define EA_ACT_REL_GPR    5'h0F
`define EA_ACT_ABS_GPR    5'h10
`define EA_ACT_DEC_STOP   5'h11
`define EA_ACT_DRIVE_HI   5'h18

// Load targets.
`define EA_TGT_SPD        3'h0
`define EA_TGT_CNT        3'h1
`define EA_TGT_LPOS       3'h2
`define EA_TGT_FP         3'h6

// Read answer timing.
`define EA_READ_MAX_NS    125
`define EA_CLK_MHZ        125
`define EA_NS_PER_US      1000

`endif

// file: verilog/ea_pkg.sv
package ea_pkg;

  typedef logic [15:0] ea_word_t;
  typedef logic [31:0] ea_long_t;

  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] level;
    logic [7:0] rise;
    logic [7:0] fall;
  } ea_pin_s;

  typedef struct packed {
    ea_word_t [3:0] mode;
    logic [3:0]     enabled;
    ea_long_t [3:0] mr;
    ea_word_t       readLow;
    ea_word_t       readHigh;
    logic           readValid;
    logic [6:0]     loadStb;
    ea_long_t [6:0] loadValue;
    logic [14:0]    driveStb;
    logic [3:0]     syncPulse;
  } ea_state_s;

endpackage : ea_pkg

// file: verilog/ea_pin_sync.sv
`include "ea_consts.svh"

module ea_pin_sync
  import ea_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] pinIn,
  output logic      [7:0] pinLevel,
  output logic      [7:0] pinRise,
  output logic      [7:0] pinFall
);

  ea_pin_s s_r;
  ea_pin_s s_nxt;
  logic [7:0] settle;

  // A pin change counts once the second and third stages agree.
  always_comb
  begin
    s_nxt    = s_r;
    s_nxt.s1 = pinIn;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    settle   = ~(s_r.s2 ^ s_r.s3) & (s_r.s3 ^ s_r.level);
    s_nxt.level = (s_r.level & ~settle) | (s_r.s3 & settle);
    s_nxt.rise  = settle & s_r.s3;
    s_nxt.fall  = settle & ~s_r.s3;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign pinLevel = s_r.level;
  assign pinRise  = s_r.rise;
  assign pinFall  = s_r.fall;

endmodule : ea_pin_sync

// file: verification/ea_host_model.sv
`include "ea_consts.svh"

module ea_host_model
  import ea_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        readValid,
  input  wire logic [15:0] readDataLow,
  input  wire logic [15:0] readDataHigh,
  output logic             cmdStb,
  output logic      [7:0]  cmdCode,
  output logic      [15:0] cmdParam
);
  timeunit 1ns;
  timeprecision 1ns;

  localparam int READ_WAIT = `EA_READ_MAX_NS * `EA_CLK_MHZ / `EA_NS_PER_US;

  initial
  begin
    cmdStb = 1'b0;
    cmdCode = 8'h00;
    cmdParam = 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One command per call; the lines show a changed value once released.
  task automatic send(input logic [7:0] code, input logic [15:0] param);
    logic [15:0] p;
    p = param;
    if (code >= `EA_CMD_MODE0 && code <= `EA_CMD_MODE3)
      p = param & `EA_MODE_KEEP_MASK;
    @(negedge clk);
    cmdStb = 1'b1;
    cmdCode = code;
    cmdParam = p;
    @(negedge clk);
    cmdStb = 1'b0;
    cmdCode = ~code;
    cmdParam = ~p;
  endtask : send

  ////////////////////////////////////////////////////////////////////////////
  // The result words are taken only once the answer is flagged.
  task automatic read(input logic [7:0] code, output ea_long_t value,
                      output logic ok);
    int n;
    send(code, 16'h0000);
    ok = 1'b0;
    value = 32'h00000000;
    for (n = 0; n < READ_WAIT && ok !== 1'b1; n++)
    begin
      if (readValid === 1'b1)
      begin
        ok = 1'b1;
        value = {readDataHigh, readDataLow};
      end
      else
        @(negedge clk);
    end
  endtask : read
endmodule : ea_host_model

// file: verification/testbench.sv
`include "ea_consts.svh"

module testbench
  import ea_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic             clk;
  logic             rst;
  logic             driving;
  logic             ok;
  logic             rdV;
  logic             cStb;
  logic      [3:0]  c;
  logic      [4:0]  a;
  logic      [11:0] ev;
  logic      [3:0]  mrStb;
  logic      [3:0]  pinOut;
  logic      [3:0]  pinOeN;
  logic      [3:0]  setEn;
  logic      [7:0]  pin;
  logic      [7:0]  cCode;
  logic      [15:0] cPar;
  logic      [15:0] rdLo;
  logic      [15:0] rdHi;
  logic      [6:0]  lStb;
  logic      [6:0]  expL;
  logic      [14:0] dStb;
  logic      [14:0] expD;
  logic [6:0][31:0] lVal;
  ea_long_t         mrData;
  ea_long_t         lpos;
  ea_long_t         rpos;
  ea_long_t         rate;
  ea_long_t         accel;
  ea_long_t         tmr;
  ea_long_t         got;
  int               bad_count = 0;
  int               cmp_count = 0;
  int               pulses = 0;
  int               base;
  logic             rise;

  ea_sync_action u_ea_sync_action (
    .clk(clk), .rst(rst), .cmdStb(cStb), .cmdCode(cCode), .cmdParam(cPar),
    .mrWriteStb(mrStb), .mrWriteData(mrData), .logicalPos(lpos),
    .realPos(rpos), .presentPulseRate(rate), .presentAccel(accel),
    .currentTimer(tmr), .driving(driving), .mrCompareTrue(ev[11:8]),
    .timerUp(ev[0]), .driveStart(ev[1]), .constSpeedStart(ev[2]),
    .constSpeedEnd(ev[3]), .driveEnd(ev[4]), .splitStart(ev[5]),
    .splitEnd(ev[6]), .splitPulse(ev[7]), .generalPinIn(pin),
    .generalPinOut(pinOut), .generalPinOeN(pinOeN), .setEnabled(setEn),
    .readDataLow(rdLo), .readDataHigh(rdHi), .readValid(rdV),
    .loadStb(lStb), .loadValue(lVal), .driveStb(dStb)
  );

  ea_host_model u_ea_host_model (
    .clk(clk), .readValid(rdV), .readDataLow(rdLo), .readDataHigh(rdHi),
    .cmdStb(cStb), .cmdCode(cCode), .cmdParam(cPar)
  );

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk)
    if (pinOut[3] === 1'b1)
      pulses <= pulses + 1;

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  task automatic chk(input ea_long_t g, input ea_long_t e);
    cmp_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("FAIL %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic rd(input logic [7:0] code, input ea_long_t e);
    u_ea_host_model.read(code, got, ok);
    chk(ok, 1);
    chk(got, e);
  endtask : rd

  task automatic mode(input int n, input logic [15:0] w);
    u_ea_host_model.send(8'(`EA_CMD_MODE0 + n), w);
  endtask : mode

  task automatic en(input logic [3:0] m);
    u_ea_host_model.send(`EA_CMD_SET_ENABLE, {12'h000, m});
  endtask : en

  task automatic pulse(input logic [11:0] m);
    @(negedge clk);
    ev = m;
    @(negedge clk);
    ev = 12'h000;
  endtask : pulse

  task automatic wt;
    repeat (8) @(negedge clk);
  endtask : wt

  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("FAIL %0t run did not finish", $time);
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst = 1'b1;
    driving = 1'b0;
    ev = 12'h000;
    mrStb = 4'h0;
    mrData = 32'hCAFE0001;
    pin = 8'h00;
    lpos = 32'hFFFFFFFB;
    rpos = 32'h12345678;
    rate = 32'h007A1200;
    accel = 32'h00000400;
    tmr = 32'h00000100;
    repeat (8) @(negedge clk);
    chk(setEn, 0);
    chk(pinOeN, 4'hF);
    rst = 1'b0;
    rd(8'h30, lpos);
    rd(8'h31, rpos);
    rd(8'h32, 0);
    driving = 1'b1;
    rd(8'h32, rate);
    u_ea_host_model.read(8'h5A, got, ok);
    chk(ok, 0);
    $display("test reads done");
    en(4'hF);
    chk(setEn, 4'hF);
    for (int t = 1; t < 10; t++)
    begin
      mode(0, 16'(16'h8110 | t));
      base = (t == 1) ? 8 : t - 2;
      pulse(12'hFFF & ~(12'h001 << base));
      chk(dStb, 0);
      pulse(12'h001 << base);
      chk(dStb, 15'h0080);
    end
    mode(0, 16'h0113);
    pulse(12'h002);
    chk(dStb, 15'h0080);
    chk(setEn, 4'hE);
    pulse(12'h002);
    chk(dStb, 0);
    en(4'h1);
    chk(setEn, 4'hF);
    $display("test triggers done");
    @(negedge clk);
    mrStb = 4'h1;
    @(negedge clk);
    mrStb = 4'h0;
    for (int k = 1; k < 25; k++)
    begin
      a = k[4:0];
      if (a == 3 || (a > 4 && a < 10))
        continue;
      mode(0, 16'(16'h8003 | (k << 4)));
      expL = (a == 1) ? 7'h01 : (a == 2 || a == 15) ? 7'h02 :
             (a == 4) ? 7'h04 : (a == 16) ? 7'h40 : 7'h00;
      expD = (a >= 10) ? 15'(1 << (a - 10)) : 15'h0000;
      pulse(12'h002);
      chk(lStb, expL);
      chk(dStb, expD);
      for (int i = 0; i < 7; i++)
        if (expL[i])
          chk(lVal[i], 32'hCAFE0001);
    end
    mode(0, 16'h0000);
    for (int n = 1; n < 4; n++)
    begin
      mode(n, 16'h8043);
      pulse(12'h002);
      chk(lStb, 7'(1 << (n + 2)));
      mode(n, 16'h0000);
    end
    $display("test actions done");
    mode(0, 16'h8110);
    mode(3, 16'h02A6);
    pulse(12'h010);
    chk(dStb, 15'h0081);
    chk(setEn, 4'h7);
    en(4'hF);
    $display("test chaining done");
    for (int k = 0; k < 4; k++)
      mode(k, 16'(16'h8002 | ((8 - k) << 4)));
    pulse(12'h001);
    rd(8'h34, rate);
    rd(8'h35, tmr);
    rd(8'h36, rpos);
    rd(8'h37, lpos);
    lpos = 32'h80000000;
    pulse(12'h001);
    rd(8'h37, lpos);
    chk(setEn, 4'hF);
    mode(1, 16'h8082);
    pulse(12'h001);
    rd(8'h35, accel);
    $display("test saves done");
    for (int j = 10; j < 16; j++)
    begin
      c = j[3:0];
      rise = (c == 4'hA || c == 4'hC || c == 4'hD);
      mode(3, 16'(16'h8090 | j));
      pin[3] = ~rise;
      pin[7] = (c > 4'hB) ? c[0] : 1'b0;
      wt();
      base = pulses;
      pin[3] = rise;
      wt();
      chk(pulses - base, 1);
      chk(pinOeN[3], 0);
      if (c > 4'hB)
      begin
        pin[3] = ~rise;
        wt();
        pin[7] = ~c[0];
        wt();
        base = pulses;
        pin[3] = rise;
        wt();
        chk(pulses - base, 0);
      end
    end
    $display("test pins done");
    stop_test();
  end
endmodule : testbench
